// >>> pkg/swpm_params.svh
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz hclk and word-aligned ahb-lite accesses
`ifndef SWPM_PARAMS_SVH
`define SWPM_PARAMS_SVH
// ==========================================
// register byte offsets
`define SWPM_OFS_LATCH 8'h00
`define SWPM_OFS_SEL1 8'h04
`define SWPM_OFS_SEL2 8'h08
`define SWPM_OFS_MASK 8'h0c
`define SWPM_OFS_CMD 8'h10
`define SWPM_OFS_WSTAT 8'h14
`define SWPM_OFS_PROT 8'h18
`define SWPM_OFS_ENCLIM 8'h1c
`define SWPM_OFS_TEMPLIM 8'h20
// ==========================================
// reset values
`define SWPM_RST_LATCH 4'h0
`define SWPM_RST_SEL 4'h0
`define SWPM_RST_MASK 16'h0000
`define SWPM_RST_ENCLIM 8'h0a
`define SWPM_RST_TEMPLIM 8'h50
// ==========================================
// mask bit positions of the warnings
`define SWPM_MB_OVL 7
`define SWPM_MB_REGEN 5
`define SWPM_MB_ENC 4
`define SWPM_MB_OSC 9
`define SWPM_MB_HEAT 11
// output selector codes
`define SWPM_SEL_ALL 4'h0
`define SWPM_SEL_OVL 4'h1
`define SWPM_SEL_REGEN 4'h2
`define SWPM_SEL_ENC 4'h5
`define SWPM_SEL_OSC 4'h7
`define SWPM_SEL_HEAT 4'hb
// ==========================================
// thresholds and protection codes
`define SWPM_LOAD_PCT 8'h55
`define SWPM_LATCH_MAX 4'ha
`define SWPM_PC_FORCED 8'h57
`define SWPM_PC_MOTOR 8'h5f
`define SWPM_PC_SINGLE 8'h2c
`define SWPM_PC_MULTI 8'h2d
`define SWPM_PC_ZMISS 8'h30
`define SWPM_PC_CSERR 8'h31
// ==========================================
// timing: one second of latch time
`define SWPM_SEC_NS 1000000000
`define SWPM_CLK_NS 25
`endif

// >>> pkg/swpm_pkg.sv
// types shared by the warning and protection manager
// assumes swpm_params.svh for numeric constants other than SWPM_NW and the warning indexes
package swpm_pkg;
    // ==========================================
    // index of each timed warning
    localparam int SWPM_NW = 5;
    typedef enum logic [2:0] {
        W_OVL = 3'h0,
        W_REGEN = 3'h1,
        W_ENC = 3'h2,
        W_OSC = 3'h3,
        W_HEAT = 3'h4
    } swpm_widx_t;
    // monitor values from the same clock domain
    typedef struct packed {
        logic [7:0] load_pct;
        logic [7:0] regen_pct;
        logic [7:0] enc_err_cnt;
        logic [7:0] amp_temp;
        logic osc_det;
        logic enc_overheat;
        logic enc_is_inc20;
        logic battery_warn;
        logic life_warn;
    } swpm_mon_t;
    // encoder fault reports
    typedef struct packed {
        logic single_turn_err;
        logic multi_turn_err;
        logic z_missing;
        logic cs_logic_err;
        logic motor_mismatch;
        logic [2:0] motor_sub;
    } swpm_enc_t;
    // latched protection code
    typedef struct packed {
        logic valid;
        logic [2:0] sub;
        logic [7:0] main;
    } swpm_prot_t;
endpackage : swpm_pkg

// >>> rtl/swpm_top.sv
// warning latch, masking, output routing and protection codes
// assumes one ahb-lite master, monitors on hclk, forced alarm on a pin
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "swpm_params.svh"
module swpm_top
    import swpm_pkg::*;
#(
    parameter int SEC_CYCLES = `SWPM_SEC_NS / `SWPM_CLK_NS
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // monitors and encoder reports
    input swpm_mon_t mon,
    input swpm_enc_t enc,
    input wire logic forced_alarm_pin,
    // outputs
    output logic warning_output_one,
    output logic warning_output_two,
    output swpm_prot_t prot
);
    // width of the per-warning cycle counter
    localparam int CW = $clog2(SEC_CYCLES + 1);

    // ==========================================
    // helpers
    // selector code to warning vector
    // unlisted codes decode to no warning at all
    function automatic logic [SWPM_NW-1:0] sel_dec(input logic [3:0] s);
        logic [SWPM_NW-1:0] v;
        v = '0;
        unique case (s)
            `SWPM_SEL_OVL: v[W_OVL] = 1'b1;
            `SWPM_SEL_REGEN: v[W_REGEN] = 1'b1;
            `SWPM_SEL_ENC: v[W_ENC] = 1'b1;
            `SWPM_SEL_OSC: v[W_OSC] = 1'b1;
            `SWPM_SEL_HEAT: v[W_HEAT] = 1'b1;
            default: v = '0;
        endcase
        return v;
    endfunction : sel_dec

    // route one output from its selector
    // selector 0 also carries the battery and life warnings
    function automatic logic route(input logic [3:0] s, input logic [SWPM_NW-1:0] w,
                                   input logic other);
        if (s == `SWPM_SEL_ALL)
            return (|w) | other;
        return |(w & sel_dec(s));
    endfunction : route

    // ==========================================
    // ahb-lite slave, zero wait states
    // configuration and status state
    logic [3:0] latch_ff;
    logic [3:0] sel1_ff;
    logic [3:0] sel2_ff;
    logic [15:0] mask_ff;
    logic [7:0] enclim_ff;
    logic [7:0] templim_ff;
    logic [7:0] wa_ff;
    logic we_ff;
    logic clr_ff;
    logic [31:0] rd_ff;
    logic [SWPM_NW-1:0] act_ff;
    logic batt_ff;
    logic life_ff;
    swpm_prot_t prot_ff;
    logic ap;
    logic [31:0] rmux;

    // address phase qualifier; idle and busy transfers ignored
    assign ap = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rd_ff;

    // read mux, unmapped reads zero
    // fields sit in the low bits, upper bits read zero
    always_comb
    begin
        rmux = 32'h0000_0000;
        unique case (haddr[7:0])
            `SWPM_OFS_LATCH: rmux[3:0] = latch_ff;
            `SWPM_OFS_SEL1: rmux[3:0] = sel1_ff;
            `SWPM_OFS_SEL2: rmux[3:0] = sel2_ff;
            `SWPM_OFS_MASK: rmux[15:0] = mask_ff;
            `SWPM_OFS_WSTAT: rmux[6:0] = {life_ff, batt_ff, act_ff};
            `SWPM_OFS_PROT: rmux[11:0] = prot_ff;
            `SWPM_OFS_ENCLIM: rmux[7:0] = enclim_ff;
            `SWPM_OFS_TEMPLIM: rmux[7:0] = templim_ff;
            default: rmux = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000)
            rmux = 32'h0000_0000;
    end

    // address phase capture and read data
    // read data frozen at the address edge, stands all data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wa_ff <= 8'h00;
            we_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
        end
        else
        begin
            we_ff <= ap & hwrite & (haddr[31:8] == 24'h00_0000);
            if (ap)
                wa_ff <= haddr[7:0];
            if (ap & ~hwrite)
                rd_ff <= rmux;
        end
    end

    // configuration registers, written in data phase
    // hsize ignored: every register is one whole word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_ff <= `SWPM_RST_LATCH;
            sel1_ff <= `SWPM_RST_SEL;
            sel2_ff <= `SWPM_RST_SEL;
            mask_ff <= `SWPM_RST_MASK;
            enclim_ff <= `SWPM_RST_ENCLIM;
            templim_ff <= `SWPM_RST_TEMPLIM;
        end
        else if (we_ff)
        begin
            unique case (wa_ff)
                `SWPM_OFS_LATCH:
                begin
                    // values above 10 saturate
                    if (hwdata[3:0] > `SWPM_LATCH_MAX)
                        latch_ff <= `SWPM_LATCH_MAX;
                    else
                        latch_ff <= hwdata[3:0];
                end
                `SWPM_OFS_SEL1: sel1_ff <= hwdata[3:0];
                `SWPM_OFS_SEL2: sel2_ff <= hwdata[3:0];
                `SWPM_OFS_MASK: mask_ff <= hwdata[15:0];
                `SWPM_OFS_ENCLIM: enclim_ff <= hwdata[7:0];
                `SWPM_OFS_TEMPLIM: templim_ff <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // alarm clear command, one-cycle pulse
    // a cause present at the clear edge keeps its state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            clr_ff <= 1'b0;
        else
            clr_ff <= we_ff & (wa_ff == `SWPM_OFS_CMD) & hwdata[0];
    end

    // ==========================================
    // warning detection
    logic [SWPM_NW-1:0] raw;
    logic [SWPM_NW-1:0] msk;
    logic [SWPM_NW-1:0] cond;

    // raw conditions, then the mask
    always_comb
    begin
        raw[W_OVL] = mon.load_pct > `SWPM_LOAD_PCT;
        raw[W_REGEN] = mon.regen_pct > `SWPM_LOAD_PCT;
        raw[W_ENC] = mon.enc_err_cnt > enclim_ff;
        raw[W_OSC] = mon.osc_det;
        raw[W_HEAT] = (mon.amp_temp > templim_ff)
            | (mon.enc_overheat & mon.enc_is_inc20);
        msk[W_OVL] = mask_ff[`SWPM_MB_OVL];
        msk[W_REGEN] = mask_ff[`SWPM_MB_REGEN];
        msk[W_ENC] = mask_ff[`SWPM_MB_ENC];
        msk[W_OSC] = mask_ff[`SWPM_MB_OSC];
        msk[W_HEAT] = mask_ff[`SWPM_MB_HEAT];
        cond = raw & ~msk;
    end

    // ==========================================
    // per-warning latch timers
    logic [CW-1:0] cyc_ff [SWPM_NW];
    logic [3:0] sec_ff [SWPM_NW];
    logic [SWPM_NW-1:0] sec_tick;

    // one-second enable pulse per warning, from its own divider
    always_comb
    begin
        for (int i = 0; i < SWPM_NW; i++)
            sec_tick[i] = (cyc_ff[i] == CW'(SEC_CYCLES - 1));
    end

    // a present condition rearms; the count starts once it clears
    // latch 0 never counts, so the warning waits for alarm clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            act_ff <= '0;
            for (int i = 0; i < SWPM_NW; i++)
            begin
                cyc_ff[i] <= '0;
                sec_ff[i] <= 4'h0;
            end
        end
        else
        begin
            for (int i = 0; i < SWPM_NW; i++)
            begin
                if (cond[i])
                begin
                    // condition present: assert and rearm timer
                    act_ff[i] <= 1'b1;
                    cyc_ff[i] <= '0;
                    sec_ff[i] <= 4'h0;
                end
                else if (msk[i] | clr_ff)
                begin
                    act_ff[i] <= 1'b0;
                end
                else if (act_ff[i] && latch_ff != 4'h0)
                begin
                    // counting from the moment the condition cleared
                    if (sec_tick[i])
                    begin
                        cyc_ff[i] <= '0;
                        sec_ff[i] <= sec_ff[i] + 4'h1;
                        if (sec_ff[i] + 4'h1 >= latch_ff)
                            act_ff[i] <= 1'b0;
                    end
                    else
                        cyc_ff[i] <= cyc_ff[i] + CW'(1);
                end
            end
        end
    end

    // battery and life warnings, held until alarm clear
    // no timer: the latch setting never releases these
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            batt_ff <= 1'b0;
            life_ff <= 1'b0;
        end
        else
        begin
            batt_ff <= mon.battery_warn | (batt_ff & ~clr_ff);
            life_ff <= mon.life_warn | (life_ff & ~clr_ff);
        end
    end

    // ==========================================
    // warning outputs
    // registered so selector writes never glitch the pins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            warning_output_one <= 1'b0;
            warning_output_two <= 1'b0;
        end
        else
        begin
            warning_output_one <= route(sel1_ff, act_ff, batt_ff | life_ff);
            warning_output_two <= route(sel2_ff, act_ff, batt_ff | life_ff);
        end
    end

    // ==========================================
    // forced alarm pin synchroniser
    // three stages against metastability; a level counts only
    // once stages two and three agree
    logic [2:0] fa_sync_ff;
    logic fa_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fa_sync_ff <= 3'b000;
            fa_ff <= 1'b0;
        end
        else
        begin
            fa_sync_ff <= {fa_sync_ff[1:0], forced_alarm_pin};
            if (fa_sync_ff[1] == fa_sync_ff[2])
                fa_ff <= fa_sync_ff[2];
        end
    end

    // ==========================================
    // protection trip, first cause wins until alarm clear
    // priority: forced alarm, motor, single, multi, z-phase, sense
    swpm_prot_t nxt_prot;

    always_comb
    begin
        nxt_prot = '0;
        nxt_prot.valid = 1'b1;
        if (fa_ff)
            nxt_prot.main = `SWPM_PC_FORCED;
        else if (enc.motor_mismatch)
        begin
            nxt_prot.main = `SWPM_PC_MOTOR;
            nxt_prot.sub = (enc.motor_sub > 3'h4) ? 3'h4 : enc.motor_sub;
        end
        else if (enc.single_turn_err)
            nxt_prot.main = `SWPM_PC_SINGLE;
        else if (enc.multi_turn_err)
            nxt_prot.main = `SWPM_PC_MULTI;
        else if (enc.z_missing)
            nxt_prot.main = `SWPM_PC_ZMISS;
        else if (enc.cs_logic_err)
            nxt_prot.main = `SWPM_PC_CSERR;
        else
            nxt_prot = '0;
    end

    // hold the code; alarm clear reloads a standing cause
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prot_ff <= '0;
        else if (!prot_ff.valid || (clr_ff && nxt_prot.valid))
            prot_ff <= nxt_prot;
        else if (clr_ff)
            prot_ff <= '0;
    end

    // protection code straight from its register
    assign prot = prot_ff;
endmodule : swpm_top

// >>> verif/swpm_asserts.sv
// concurrent checks on the warning manager ports
// assumes binding to swpm_top; shadows ahb writes to track setup
`timescale 1ns/1ps
`include "swpm_params.svh"
module swpm_asserts
    import swpm_pkg::*;
#(
    parameter int SEC_CYCLES = 10
)(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // monitors
    input swpm_mon_t mon,
    input swpm_enc_t enc,
    input wire logic forced_alarm_pin,
    // outputs
    input wire logic warning_output_one,
    input wire logic warning_output_two,
    input swpm_prot_t prot
);
    logic dw_ff;
    logic [7:0] da_ff;
    logic [3:0] wr_ff;
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] lt_ff;
    logic [15:0] mk_ff;
    logic quiet;
    // no write in flight or just landed
    assign quiet = !dw_ff && wr_ff == 4'h0;
    // ==========================================
    // shadow of the setup written over ahb
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dw_ff <= 1'b0;
            da_ff <= 8'h0;
            wr_ff <= 4'h0;
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            lt_ff <= 4'h0;
            mk_ff <= 16'h0;
        end
        else
        begin
            dw_ff <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1])
                da_ff <= haddr[7:0];
            wr_ff <= {wr_ff[2:0], dw_ff};
            if (dw_ff && da_ff == `SWPM_OFS_SEL1)
                s1_ff <= hwdata[3:0];
            if (dw_ff && da_ff == `SWPM_OFS_SEL2)
                s2_ff <= hwdata[3:0];
            if (dw_ff && da_ff == `SWPM_OFS_MASK)
                mk_ff <= hwdata[15:0];
            if (dw_ff && da_ff == `SWPM_OFS_LATCH)
                lt_ff <= (hwdata[3:0] > 4'ha) ? 4'ha : hwdata[3:0];
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ovl_to_one: assert property (
        (mon.load_pct > 8'h55 && !mk_ff[7] && s1_ff == 4'h1)[*3] |-> warning_output_one)
        else $error("overload missing on output one");
    a_heat_or_two: assert property (
        (mon.amp_temp > 8'h50 && !mk_ff[11] && s2_ff == 4'h0)[*3] |-> warning_output_two)
        else $error("overheat missing on output two");
    a_mask_blocks: assert property (
        (mk_ff[7] && s1_ff == 4'h1)[*3] |-> !warning_output_one)
        else $error("masked warning drives output");
    a_same_scheme: assert property (
        (s1_ff == s2_ff)[*2] |-> warning_output_one == warning_output_two)
        else $error("outputs differ on equal selectors");
    a_zero_holds: assert property (
        warning_output_one && s1_ff == 4'h1 && lt_ff == 4'h0 && quiet |=> warning_output_one)
        else $error("infinite latch released");
    a_drop_cured: assert property (
        $fell(warning_output_one) && s1_ff == 4'h1 && quiet |-> $past(mon.load_pct, 2) <= 8'h55)
        else $error("warning dropped while present");
    a_zmiss_code: assert property (
        (!forced_alarm_pin)[*5] ##0 (!prot.valid && enc.z_missing && !enc.single_turn_err
        && !enc.multi_turn_err && !enc.motor_mismatch) |=> prot == {1'b1, 3'h0, `SWPM_PC_ZMISS})
        else $error("z-phase code wrong");
    a_motor_sub: assert property (
        prot.valid && prot.main == `SWPM_PC_MOTOR |-> prot.sub <= 3'h4)
        else $error("motor sub code out of range");
    a_forced_trip: assert property (
        forced_alarm_pin[*8] |-> prot.valid)
        else $error("forced alarm did not trip");
endmodule : swpm_asserts

// >>> verif/swpm_far_model.sv
// far side: monitors, encoder reports and the forced alarm pin
// assumes requests from the bench; reports move just after hclk edges
`timescale 1ns/1ps
module swpm_far_model
    import swpm_pkg::*;
(
    // clock
    input wire logic hclk,
    // requests from the bench
    input swpm_mon_t mon_req,
    input swpm_enc_t enc_req,
    input wire logic alarm_req,
    // toward the block
    output swpm_mon_t mon,
    output swpm_enc_t enc,
    output logic forced_alarm_pin
);
    // ==========================================
    // quiet reports until the first edge
    initial
    begin
        mon = '0;
        enc = '0;
        forced_alarm_pin = 1'b0;
    end
    // reports launched like same-clock monitors
    always @(posedge hclk)
    begin
        mon <= mon_req;
        enc <= enc_req;
        forced_alarm_pin <= alarm_req;
    end
endmodule : swpm_far_model

// >>> verif/tb_top.sv
// self-checking bench for the warning and protection manager
// assumes a short second (SEC_CYCLES) and a zero-wait ahb slave
`timescale 1ns/1ps
`include "swpm_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module tb_top
    import swpm_pkg::*;
;
    localparam int SEC = 10;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rv;
    swpm_mon_t mon_req = '0;
    swpm_mon_t mon;
    swpm_enc_t enc_req = '0;
    swpm_enc_t enc;
    logic alarm_req = 1'b0;
    logic pin;
    logic wo1;
    logic wo2;
    swpm_prot_t prot;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int code[5] = '{1, 2, 5, 7, 11};
    int mbit[5] = '{7, 5, 4, 9, 11};
    int pm[6] = '{8'h30, 8'h31, 8'h2c, 8'h2d, 8'h5f, 8'h57};
    logic [7:0] eb[6] = '{8'h20, 8'h10, 8'h80, 8'h40, 8'h08, 8'h00};
    bit act[5];
    // ==========================================
    // clock, timeout, design and far side
    always #12.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            finish_test();
        end
    end
    swpm_top #(.SEC_CYCLES(SEC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mon(mon), .enc(enc), .forced_alarm_pin(pin), .warning_output_one(wo1),
        .warning_output_two(wo2), .prot(prot));
    swpm_far_model far (.hclk(hclk), .mon_req(mon_req), .enc_req(enc_req),
        .alarm_req(alarm_req), .mon(mon), .enc(enc), .forced_alarm_pin(pin));
    // ==========================================
    // bus, stimulus and model helpers
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d);
    endtask : wr
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic cond(input int i, input bit on);
        @(posedge hclk);
        case (i)
            0: mon_req.load_pct <= on ? 8'h56 + 8'($urandom_range(0, 99)) : 8'h55;
            1: mon_req.regen_pct <= on ? 8'h56 : 8'h55;
            2: mon_req.enc_err_cnt <= on ? 8'h0b : 8'h0a;
            3: mon_req.osc_det <= on;
            default: mon_req.amp_temp <= on ? 8'h51 : 8'h50;
        endcase
    endtask : cond
    function automatic logic expo(input int sel);
        expo = 1'b0;
        for (int k = 0; k < 5; k++)
            if (act[k] && (sel == 0 || sel == code[k]))
                expo = 1'b1;
    endfunction : expo
    task automatic finish_test();
        $display("counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(32'hbb4d4101));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(8'h24 + 8'(4 * $urandom_range(0, 50)), 1'b0, 32'h0);
        `CHK(rv, 32'h0)
        wr(`SWPM_OFS_LATCH, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            wr(`SWPM_OFS_SEL1, code[i]);
            wr(`SWPM_OFS_SEL2, (i == 4) ? 0 : code[i + 1]);
            cond(i, 1'b1);
            act[i] = 1'b1;
            tick(4);
            `CHK(wo1, expo(code[i]))
            `CHK(wo2, expo((i == 4) ? 0 : code[i + 1]))
            ahb(`SWPM_OFS_WSTAT, 1'b0, 32'h0);
            `CHK(rv[i], 1'b1)
            wr(`SWPM_OFS_MASK, 32'h1 << mbit[i]);
            act[i] = 1'b0;
            tick(3);
            `CHK(wo1, expo(code[i]))
            cond(i, 1'b0);
            wr(`SWPM_OFS_MASK, 32'h0);
            wr(`SWPM_OFS_CMD, 32'h1);
        end
        $display("routing and mask test done");
        wr(`SWPM_OFS_LATCH, 32'hc);
        ahb(`SWPM_OFS_LATCH, 1'b0, 32'h0);
        `CHK(rv, 32'ha)
        wr(`SWPM_OFS_LATCH, 32'h2);
        wr(`SWPM_OFS_SEL1, 32'h1);
        wr(`SWPM_OFS_SEL2, 32'h2);
        cond(0, 1'b1);
        cond(1, 1'b1);
        tick(4);
        cond(0, 1'b0);
        tick(10);
        cond(1, 1'b0);
        tick(8);
        `CHK({wo1, wo2}, 2'h3)
        tick(8);
        `CHK({wo1, wo2}, 2'h1)
        tick(10);
        `CHK(wo2, 1'b0)
        wr(`SWPM_OFS_LATCH, 32'h0);
        cond(0, 1'b1);
        tick(4);
        cond(0, 1'b0);
        tick(50);
        `CHK(wo1, 1'b1)
        wr(`SWPM_OFS_SEL1, 32'h2);
        tick(3);
        `CHK(wo1, 1'b0)
        wr(`SWPM_OFS_SEL1, 32'h1);
        wr(`SWPM_OFS_CMD, 32'h1);
        tick(3);
        `CHK(wo1, 1'b0)
        $display("latch test done");
        wr(`SWPM_OFS_LATCH, 32'h1);
        wr(`SWPM_OFS_SEL1, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge hclk);
            mon_req.battery_warn <= (k == 0);
            mon_req.life_warn <= (k == 1);
            tick(3);
            @(posedge hclk);
            mon_req.battery_warn <= 1'b0;
            mon_req.life_warn <= 1'b0;
            tick(40);
            `CHK(wo1, 1'b1)
            wr(`SWPM_OFS_CMD, 32'h1);
            tick(3);
            `CHK(wo1, 1'b0)
        end
        wr(`SWPM_OFS_SEL1, 32'hb);
        @(posedge hclk);
        mon_req.enc_overheat <= 1'b1;
        tick(4);
        `CHK(wo1, 1'b0)
        mon_req.enc_is_inc20 <= 1'b1;
        tick(4);
        `CHK(wo1, 1'b1)
        mon_req.enc_overheat <= 1'b0;
        wr(`SWPM_OFS_CMD, 32'h1);
        $display("held warning test done");
        for (int k = 0; k < 6; k++)
        begin
            rv = $urandom_range(0, 7);
            @(posedge hclk);
            enc_req <= swpm_enc_t'(eb[k] | ((k == 4) ? rv[7:0] : 8'h0));
            alarm_req <= (k == 5);
            tick(8);
            `CHK(prot, {1'b1, (k == 4 && rv > 4) ? 3'h4 : 3'((k == 4) ? rv : 0), 8'(pm[k])})
            enc_req <= '0;
            alarm_req <= 1'b0;
            tick(6);
            wr(`SWPM_OFS_CMD, 32'h1);
            tick(3);
            `CHK(prot.valid, 1'b0)
        end
        $display("protection test done");
        finish_test();
    end
endmodule : tb_top
bind swpm_top swpm_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mon(mon), .enc(enc), .forced_alarm_pin(forced_alarm_pin),
    .warning_output_one(warning_output_one), .warning_output_two(warning_output_two),
    .prot(prot));
